// ### verilog/idrpc_regs.svh
// register indices, field positions, reset values and timing counts
`ifndef IDRPC_REGS_SVH
`define IDRPC_REGS_SVH

// register indices; the byte address on the bus is index * 4
`define IDRPC_IDX_POWER_MGMT_CTRL    8'hC4
`define IDRPC_IDX_PROTECT_UNLOCK_KEY 8'hC7
`define IDRPC_IDX_POWER_CTRL_REG     8'hD0
`define IDRPC_IDX_WATCHDOG_CTRL_REG  8'hD1
`define IDRPC_IDX_WATCHDOG_CFG       8'hD2

// field positions
`define IDRPC_PMR_XRAM_EN_BIT        0
`define IDRPC_PMR_ALE_SUPPRESS_BIT   2
`define IDRPC_PCR_IDLE_BIT           0
`define IDRPC_WDC_RESTART_BIT        0
`define IDRPC_WDC_RST_EN_BIT         1
`define IDRPC_WDC_RST_CAUSE_BIT      2
`define IDRPC_WDC_TIMEOUT_BIT        3
`define IDRPC_WDC_POWER_ON_BIT       6
`define IDRPC_WCF_INT_EN_BIT         2

// reset values and writable masks
`define IDRPC_PMR_RESET              8'h00
`define IDRPC_PMR_WR_MASK            8'h05
`define IDRPC_WCF_RESET              8'h00
`define IDRPC_WCF_WR_MASK            8'h07
`define IDRPC_WDC_POR_RESET          8'h40
`define IDRPC_RESET_VECTOR           16'h0000

// unlock keys
`define IDRPC_KEY_FIRST              8'hAA
`define IDRPC_KEY_SECOND             8'h55

// timing
`define IDRPC_CLKS_PER_MC            4
`define IDRPC_EXT_RST_MIN_MC         2
`define IDRPC_EXT_RST_MIN_CLKS       (`IDRPC_EXT_RST_MIN_MC * `IDRPC_CLKS_PER_MC)
`define IDRPC_TA_WINDOW_MC           3
`define IDRPC_TA_WINDOW_CLKS         (`IDRPC_TA_WINDOW_MC * `IDRPC_CLKS_PER_MC)
`define IDRPC_WDT_RST_MC             2
`define IDRPC_WDT_RST_CLKS           (`IDRPC_WDT_RST_MC * `IDRPC_CLKS_PER_MC)
`define IDRPC_WDT_RESET_DELAY_CLKS   512

`endif

// ### verilog/idrpc_pkg.sv
// types shared by the idle, reset and power control block
package idrpc_pkg;

	typedef enum logic [1:0] {TA_LOCKED, TA_KEY1_SEEN, TA_OPEN} idrpc_ta_state_t;

	typedef enum logic [1:0] {WDT_STOPPED, WDT_COUNTING, WDT_GRACE, WDT_RESETTING} idrpc_wdt_state_t;

	typedef struct packed {
		logic ale;
		logic program_fetch_strobe;
		logic ext_access;
	} idrpc_strobe_t;

	typedef struct packed {
		logic       write;
		logic [7:0] idx;
	} idrpc_bus_req_t;

endpackage

// ### verilog/idrpc_rst_filter.sv
// qualifies a level that must stay high for a least number of clocks
`timescale 1ns/1ps
module idrpc_rst_filter #(
	parameter int unsigned MIN_CLKS = 8
) (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// level in, qualified level out
	input  wire logic level,
	output logic      valid
);
	localparam int unsigned W = $clog2(MIN_CLKS + 1);

	logic [W-1:0] cnt_q;

	// saturates, so a long pulse keeps the output asserted
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
		end else if (!level) begin
			cnt_q <= '0;
		end else if (cnt_q != W'(MIN_CLKS)) begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	assign valid = (cnt_q == W'(MIN_CLKS));
endmodule

// ### verilog/idrpc_wdt.sv
// watchdog interval counter, post-timeout reset delay and reset pulse
`timescale 1ns/1ps
`include "idrpc_regs.svh"
module idrpc_wdt
	import idrpc_pkg::*;
#(
	parameter int unsigned INTERVAL_0 = 131072,
	parameter int unsigned INTERVAL_1 = 1048576,
	parameter int unsigned INTERVAL_2 = 8388608,
	parameter int unsigned INTERVAL_3 = 67108864
) (
	// clock and power-on reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// control
	input  wire logic       restart,
	input  wire logic [1:0] interval_sel,
	input  wire logic       reset_en,
	// events
	output logic            timeout,
	output logic            wdt_reset
);
	idrpc_wdt_state_t state_q;
	logic [26:0]      cnt_q;
	logic [26:0]      limit;

	always_comb begin
		case (interval_sel)
			2'h0:    limit = 27'(INTERVAL_0 - 1);
			2'h1:    limit = 27'(INTERVAL_1 - 1);
			2'h2:    limit = 27'(INTERVAL_2 - 1);
			default: limit = 27'(INTERVAL_3 - 1);
		endcase
	end

	assign timeout   = (state_q == WDT_COUNTING) && (cnt_q == limit) && !restart;
	assign wdt_reset = (state_q == WDT_RESETTING);

	// stopped after power-on until software restarts it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= WDT_STOPPED;
			cnt_q   <= '0;
		end else if (restart) begin
			state_q <= WDT_COUNTING;
			cnt_q   <= '0;
		end else begin
			case (state_q)
				WDT_STOPPED: begin
					cnt_q <= '0;
				end
				WDT_COUNTING: begin
					if (cnt_q == limit) begin
						cnt_q <= '0;
						if (reset_en) begin
							state_q <= WDT_GRACE;
						end
					end else begin
						cnt_q <= cnt_q + 27'h0000001;
					end
				end
				WDT_GRACE: begin
					if (cnt_q == 27'(`IDRPC_WDT_RESET_DELAY_CLKS - 1)) begin
						cnt_q   <= '0;
						state_q <= reset_en ? WDT_RESETTING : WDT_COUNTING;
					end else begin
						cnt_q <= cnt_q + 27'h0000001;
					end
				end
				WDT_RESETTING: begin
					// a watchdog reset restarts the timer rather than stopping it
					if (cnt_q == 27'(`IDRPC_WDT_RST_CLKS - 1)) begin
						cnt_q   <= '0;
						state_q <= WDT_COUNTING;
					end else begin
						cnt_q <= cnt_q + 27'h0000001;
					end
				end
				default: begin
					state_q <= WDT_STOPPED;
					cnt_q   <= '0;
				end
			endcase
		end
	end
endmodule

// ### verilog/idrpc_top.sv
// idle, reset-source and power control with timed-access unlock on an AHB-Lite slave
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "idrpc_regs.svh"

// Operation
// - writing idle bit enters idle after write
// - idle stops CPU clock, peripherals keep running
// - idle freezes all CPU state
// - idle drives strobes high, holds port pins
// - enabled interrupt clears idle and wakes
// - any reset source also ends idle
// - reset pin valid only after eight clocks
// - reset loads zero vector, registers to defaults
// - execution restarts immediately after reset ends
// - watchdog runs in idle, interrupt wakes
// - watchdog control reset value per source
// - power-on flag set only by power-on
// - watchdog reset sets cause flag, power-on clears
// - reset enable cleared only by power-on or a timed-access write
// - correct keys open three machine-cycle window
// - suppress bit stops on-chip latch strobe
// - enable bit switches on-chip data SRAM
// - watchdog reset lasts two machine cycles
module idrpc_top
	import idrpc_pkg::*;
#(
	parameter int unsigned WDT_INTERVAL_0 = 131072,
	parameter int unsigned WDT_INTERVAL_1 = 1048576,
	parameter int unsigned WDT_INTERVAL_2 = 8388608,
	parameter int unsigned WDT_INTERVAL_3 = 67108864
) (
	// clock and power-on reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// AHB-Lite slave
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic               hresp,
	output logic [31:0]        hrdata,
	// external reset pin
	input  wire logic          ext_rst_pin,
	// processor core side
	input  wire idrpc_strobe_t core_strobe,
	input  wire logic          irq_wake,
	output logic               core_reset,
	output logic [15:0]        reset_vector,
	output logic               cpu_clk_en,
	output logic               wdt_irq,
	// device pins and memory control
	output logic               ale_pin,
	output logic               program_fetch_strobe_pin,
	output logic               port_hold,
	output logic               xram_en
);
	// bus
	idrpc_bus_req_t  req_q;
	logic            req_valid_q;
	logic [31:0]     hrdata_q;
	logic [7:0]      rd_value;
	logic            take;
	logic            wr_en;
	logic [7:0]      wdata;
	logic            wr_pmr;
	logic            wr_key;
	logic            wr_pcr;
	logic            wr_wdc;
	logic            wr_wcf;
	// reset sources
	logic            ext_valid;
	logic            wdt_reset;
	logic            sreset;
	logic            core_reset_q;
	// state and registers
	logic            idle_q;
	logic [7:0]      pmr_q;
	logic [7:0]      wdc_q;
	logic [7:0]      wcf_q;
	logic            wake;
	logic            wdt_timeout;
	logic            wdt_restart;
	logic            ale_pin_q;
	logic            program_fetch_strobe_pin_q;
	// timed access
	idrpc_ta_state_t ta_state_q;
	logic [3:0]      ta_cnt_q;
	logic            prot_open;
	// assertion helper
	logic [3:0]      open_len_q;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// ---------------- AHB-Lite slave ----------------
	// zero wait states; every access answers OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign take      = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_valid_q <= 1'b0;
			req_q       <= '0;
		end else begin
			req_valid_q <= take;
			if (take) begin
				req_q.write <= hwrite;
				req_q.idx   <= haddr[9:2];
			end
		end
	end

	// key register is write-only; unmapped indices read zero
	always_comb begin
		case (haddr[9:2])
			`IDRPC_IDX_POWER_MGMT_CTRL:   rd_value = pmr_q;
			`IDRPC_IDX_POWER_CTRL_REG:    rd_value = {7'h00, idle_q};
			`IDRPC_IDX_WATCHDOG_CTRL_REG: rd_value = wdc_q;
			`IDRPC_IDX_WATCHDOG_CFG:      rd_value = wcf_q;
			default:                      rd_value = 8'h00;
		endcase
	end

	// read data sampled in the address phase; a read right after a write to the same index returns the old value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h00000000;
		end else if (take && !hwrite) begin
			hrdata_q <= {24'h000000, rd_value};
		end
	end

	assign wr_en  = req_valid_q && req_q.write;
	assign wdata  = hwdata[7:0];
	assign wr_pmr = wr_en && (req_q.idx == `IDRPC_IDX_POWER_MGMT_CTRL);
	assign wr_key = wr_en && (req_q.idx == `IDRPC_IDX_PROTECT_UNLOCK_KEY);
	assign wr_pcr = wr_en && (req_q.idx == `IDRPC_IDX_POWER_CTRL_REG);
	assign wr_wdc = wr_en && (req_q.idx == `IDRPC_IDX_WATCHDOG_CTRL_REG);
	assign wr_wcf = wr_en && (req_q.idx == `IDRPC_IDX_WATCHDOG_CFG);

	// ---------------- reset sources ----------------
	idrpc_rst_filter #(
		.MIN_CLKS (`IDRPC_EXT_RST_MIN_CLKS)
	) u_ext_filter (
		.hclk    (hclk),
		.hresetn (hresetn),
		.level   (ext_rst_pin),
		.valid   (ext_valid)
	);

	assign sreset = ext_valid || wdt_reset;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_reset_q <= 1'b1;
		end else begin
			core_reset_q <= sreset;
		end
	end

	assign core_reset   = core_reset_q;
	assign reset_vector = `IDRPC_RESET_VECTOR;

	a_ext_rst_valid: assert property (ext_rst_pin [*8] |=> ext_valid)
		else $error("reset pin held eight clocks not accepted");
	a_ext_rst_short: assert property ($rose(ext_valid) |-> $past(ext_rst_pin, 8) && $past(ext_rst_pin, 1))
		else $error("reset accepted from a short pulse");
	a_core_rst_follow: assert property (sreset |=> core_reset && !cpu_clk_en)
		else $error("system reset not passed to the core");

	// ---------------- idle control ----------------
	assign wake = irq_wake || wdt_irq;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_q <= 1'b0;
		end else if (sreset) begin
			idle_q <= 1'b0;
		end else if (idle_q && wake) begin
			idle_q <= 1'b0;
		end else if (wr_pcr) begin
			idle_q <= wdata[`IDRPC_PCR_IDLE_BIT];
		end
	end

	// gating the enable rather than the clock keeps the core state intact
	assign cpu_clk_en = !idle_q && !core_reset_q;
	assign port_hold  = idle_q;

	a_idle_enter: assert property (wr_pcr && wdata[0] && !sreset && !idle_q |=> idle_q && !cpu_clk_en)
		else $error("idle write did not stop the core");
	a_idle_freeze: assert property (idle_q |-> !cpu_clk_en && port_hold)
		else $error("core clocked or ports released during idle");
	a_idle_wake: assert property (idle_q && irq_wake && !sreset |=> !idle_q)
		else $error("enabled interrupt did not end idle");
	a_idle_reset_exit: assert property (idle_q && sreset |=> !idle_q ##1 (core_reset || cpu_clk_en))
		else $error("reset did not end idle");
	a_no_start_delay: assert property ($fell(core_reset) && !idle_q |-> cpu_clk_en)
		else $error("core held after reset release");

	// ---------------- strobes ----------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ale_pin_q  <= 1'b1;
			program_fetch_strobe_pin_q <= 1'b1;
		end else if (idle_q) begin
			ale_pin_q  <= 1'b1;
			program_fetch_strobe_pin_q <= 1'b1;
		end else begin
			ale_pin_q  <= core_strobe.ale && (core_strobe.ext_access || !pmr_q[`IDRPC_PMR_ALE_SUPPRESS_BIT]);
			program_fetch_strobe_pin_q <= core_strobe.program_fetch_strobe;
		end
	end

	assign ale_pin  = ale_pin_q;
	assign program_fetch_strobe_pin = program_fetch_strobe_pin_q;

	a_idle_strobes: assert property (idle_q |=> ale_pin && program_fetch_strobe_pin)
		else $error("strobes not high during idle");
	a_ale_suppress: assert property (!idle_q && pmr_q[2] && !core_strobe.ext_access |=> !ale_pin)
		else $error("latch strobe pulsed while suppressed");
	a_ale_external: assert property (!idle_q && core_strobe.ale && core_strobe.ext_access |=> ale_pin)
		else $error("latch strobe missing on external access");

	// ---------------- power management and watchdog config ----------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pmr_q <= `IDRPC_PMR_RESET;
		end else if (sreset) begin
			pmr_q <= `IDRPC_PMR_RESET;
		end else if (wr_pmr) begin
			pmr_q <= wdata & `IDRPC_PMR_WR_MASK;
		end
	end

	assign xram_en = pmr_q[`IDRPC_PMR_XRAM_EN_BIT];

	a_xram_enable: assert property (wr_pmr && !sreset |=> xram_en == $past(wdata[0]))
		else $error("data SRAM enable not following register");

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wcf_q <= `IDRPC_WCF_RESET;
		end else if (sreset) begin
			wcf_q <= `IDRPC_WCF_RESET;
		end else if (wr_wcf) begin
			wcf_q <= wdata & `IDRPC_WCF_WR_MASK;
		end
	end

	// ---------------- timed access ----------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ta_state_q <= TA_LOCKED;
			ta_cnt_q   <= 4'h0;
		end else if (sreset) begin
			ta_state_q <= TA_LOCKED;
			ta_cnt_q   <= 4'h0;
		end else begin
			case (ta_state_q)
				TA_LOCKED: begin
					if (wr_key && wdata == `IDRPC_KEY_FIRST) begin
						ta_state_q <= TA_KEY1_SEEN;
					end
				end
				TA_KEY1_SEEN: begin
					if (wr_key && wdata == `IDRPC_KEY_SECOND) begin
						ta_state_q <= TA_OPEN;
						ta_cnt_q   <= 4'(`IDRPC_TA_WINDOW_CLKS - 1);
					end else if (wr_key && wdata == `IDRPC_KEY_FIRST) begin
						ta_state_q <= TA_KEY1_SEEN;
					end else if (wr_en) begin
						ta_state_q <= TA_LOCKED;
					end
				end
				TA_OPEN: begin
					if (ta_cnt_q == 4'h0) begin
						ta_state_q <= TA_LOCKED;
					end else begin
						ta_cnt_q <= ta_cnt_q - 4'h1;
					end
				end
				default: begin
					ta_state_q <= TA_LOCKED;
				end
			endcase
		end
	end

	assign prot_open = (ta_state_q == TA_OPEN);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			open_len_q <= 4'h0;
		end else if (prot_open) begin
			open_len_q <= open_len_q + 4'h1;
		end else begin
			open_len_q <= 4'h0;
		end
	end

	a_ta_window_max: assert property (prot_open |-> open_len_q < 4'hC)
		else $error("unlock window longer than three machine cycles");
	a_ta_window_len: assert property ($fell(prot_open) && !$past(sreset) |-> $past(open_len_q) == 4'hB)
		else $error("unlock window not three machine cycles");
	a_ta_abandon: assert property (ta_state_q == TA_KEY1_SEEN && wr_en && !wr_key |=> !prot_open)
		else $error("unlock not abandoned after foreign write");
	a_ta_open_seq: assert property (ta_state_q == TA_KEY1_SEEN && wr_key && wdata == 8'h55 && !sreset |=> prot_open)
		else $error("correct key pair did not open the window");

	// ---------------- watchdog control ----------------
	assign wdt_restart = wr_wdc && prot_open && wdata[`IDRPC_WDC_RESTART_BIT];

	idrpc_wdt #(
		.INTERVAL_0 (WDT_INTERVAL_0),
		.INTERVAL_1 (WDT_INTERVAL_1),
		.INTERVAL_2 (WDT_INTERVAL_2),
		.INTERVAL_3 (WDT_INTERVAL_3)
	) u_wdt (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.restart      (wdt_restart),
		.interval_sel (wcf_q[1:0]),
		.reset_en     (wdc_q[`IDRPC_WDC_RST_EN_BIT]),
		.timeout      (wdt_timeout),
		.wdt_reset    (wdt_reset)
	);

	// restart bit is self-clearing, so it never holds a one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdc_q <= `IDRPC_WDC_POR_RESET;
		end else if (sreset) begin
			wdc_q[`IDRPC_WDC_TIMEOUT_BIT] <= 1'b0;
			if (wdt_reset) begin
				wdc_q[`IDRPC_WDC_RST_CAUSE_BIT] <= 1'b1;
			end
		end else begin
			if (wr_wdc) begin
				wdc_q[`IDRPC_WDC_TIMEOUT_BIT] <= wdata[`IDRPC_WDC_TIMEOUT_BIT];
				if (!wdata[`IDRPC_WDC_POWER_ON_BIT]) begin
					wdc_q[`IDRPC_WDC_POWER_ON_BIT] <= 1'b0;
				end
				if (!wdata[`IDRPC_WDC_RST_CAUSE_BIT]) begin
					wdc_q[`IDRPC_WDC_RST_CAUSE_BIT] <= 1'b0;
				end
				if (prot_open) begin
					wdc_q[`IDRPC_WDC_RST_EN_BIT] <= wdata[`IDRPC_WDC_RST_EN_BIT];
				end
			end
			// hardware set wins over a clear in the same cycle
			if (wdt_timeout) begin
				wdc_q[`IDRPC_WDC_TIMEOUT_BIT] <= 1'b1;
			end
		end
	end

	assign wdt_irq = wdc_q[`IDRPC_WDC_TIMEOUT_BIT] && wcf_q[`IDRPC_WCF_INT_EN_BIT];

	a_wdt_wake: assert property (idle_q && wdt_irq && !sreset |=> !idle_q)
		else $error("watchdog interrupt did not wake the core");
	a_wdt_src_value: assert property (wdt_reset |=> wdc_q[2] && !wdc_q[3] && !wdc_q[0])
		else $error("watchdog reset value wrong");
	a_ext_src_keep: assert property (ext_valid && !wdt_reset |=> wdc_q[6:1] == {$past(wdc_q[6:4]), 1'b0, $past(wdc_q[2:1])})
		else $error("external reset disturbed kept bits");
	a_por_flag_only: assert property (!$rose(wdc_q[6]))
		else $error("power-on flag set outside power-on");
	a_wdt_rst_len: assert property ($rose(wdt_reset) && !wdt_restart |-> wdt_reset [*8] ##1 !wdt_reset)
		else $error("watchdog reset not two machine cycles");
	a_ta_locked_ewt: assert property (wr_wdc && !prot_open && !sreset |=> wdc_q[1] == $past(wdc_q[1]))
		else $error("protected bit written while locked");
endmodule

// ### dv/idrpc_core_model.sv
// processor core model: strobes, pending interrupt and instruction counter
`timescale 1ns/1ps
module idrpc_core_model
	import idrpc_pkg::*;
(
	// clock and reset
	input  wire logic     hclk,
	input  wire logic     hresetn,
	// from the block
	input  wire logic     core_reset,
	input  wire logic     cpu_clk_en,
	// commands from the bench
	input  wire logic     wake_req,
	input  wire logic     ext_req,
	// to the block
	output idrpc_strobe_t core_strobe,
	output logic          irq_wake,
	output logic [7:0]    instr_count
);
	// strobes pulse every other cycle only while the core is clocked
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_strobe <= '0;
			irq_wake <= 1'b0;
		end else begin
			core_strobe.ale <= cpu_clk_en & ~core_strobe.ale;
			core_strobe.program_fetch_strobe <= cpu_clk_en & ~core_strobe.ale;
			core_strobe.ext_access <= ext_req;
			irq_wake <= wake_req;
		end
	end
	// stands in for the program counter: frozen without clock, zero in reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instr_count <= 8'h00;
		end else if (core_reset) begin
			instr_count <= 8'h00;
		end else if (cpu_clk_en) begin
			instr_count <= instr_count + 8'h01;
		end
	end
endmodule

// ### dv/idrpc_top_tb.sv
// self-checking bench for the idle, reset and power control block
`timescale 1ns/1ps
`include "idrpc_regs.svh"
module idrpc_top_tb
	import idrpc_pkg::*;
;
	localparam logic [7:0] idx_pmc = `IDRPC_IDX_POWER_MGMT_CTRL;
	localparam logic [7:0] idx_key = `IDRPC_IDX_PROTECT_UNLOCK_KEY;
	localparam logic [7:0] idx_pcr = `IDRPC_IDX_POWER_CTRL_REG;
	localparam logic [7:0] idx_wdc = `IDRPC_IDX_WATCHDOG_CTRL_REG;
	localparam logic [7:0] idx_cfg = `IDRPC_IDX_WATCHDOG_CFG;
	logic          hclk = 1'b0;
	logic          hresetn = 1'b0;
	logic          hsel = 1'b0;
	logic          bus_sel = 1'b1;
	logic [31:0]   haddr = 32'h0000_0000;
	logic [1:0]    htrans = 2'h0;
	logic          hwrite = 1'b0;
	logic [31:0]   hwdata = 32'h0000_0000;
	logic          hready;
	logic          hresp;
	logic [31:0]   hrdata;
	logic          ext_rst_pin = 1'b0;
	logic          wake_req = 1'b0;
	logic          ext_req = 1'b0;
	idrpc_strobe_t core_strobe;
	logic          irq_wake, core_reset, cpu_clk_en, wdt_irq;
	logic          ale_pin, program_fetch_strobe_pin, port_hold, xram_en;
	logic [15:0]   reset_vector;
	logic [7:0]    instr_count;
	int            n_mismatch = 0;
	int            samples_checked = 0;
	int            cycles = 0;

	always #5 hclk = ~hclk;

	// short watchdog intervals keep the run brief
	idrpc_top #(.WDT_INTERVAL_0(64), .WDT_INTERVAL_1(128), .WDT_INTERVAL_2(256), .WDT_INTERVAL_3(512)) u_idrpc_top (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.ext_rst_pin(ext_rst_pin), .core_strobe(core_strobe), .irq_wake(irq_wake), .core_reset(core_reset),
		.reset_vector(reset_vector), .cpu_clk_en(cpu_clk_en), .wdt_irq(wdt_irq), .ale_pin(ale_pin),
		.program_fetch_strobe_pin(program_fetch_strobe_pin), .port_hold(port_hold), .xram_en(xram_en));
	idrpc_core_model u_idrpc_core_model (
		.hclk(hclk), .hresetn(hresetn), .core_reset(core_reset), .cpu_clk_en(cpu_clk_en),
		.wake_req(wake_req), .ext_req(ext_req), .core_strobe(core_strobe), .irq_wake(irq_wake),
		.instr_count(instr_count));

	task automatic end_of_test();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one single AHB transfer; read data taken at the data-phase edge
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= bus_sel;
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		bus(1'b1, idx, d, rd);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'b0, idx, 8'h00, rd);
		chk(rd, exp);
		chk(hresp, 32'h0000_0000);
	endtask

	// ors a pin over several cycles, skipping the pipeline first
	task automatic seen(input int n, output logic s, input logic which);
		s = 1'b0;
		repeat (2) @(posedge hclk);
		repeat (n) begin
			@(posedge hclk);
			#1;
			s |= which ? core_reset : ale_pin;
		end
	endtask

	task automatic t_reset_values();
		// an unselected transfer must leave the registers alone
		bus_sel = 1'b0;
		wr(idx_pmc, 8'h05);
		bus_sel = 1'b1;
		rdchk(idx_pmc, 32'h0000_0000);
		rdchk(idx_wdc, 32'h0000_0040);
		rdchk(8'h00, 32'h0000_0000);
		chk(reset_vector, 32'h0000_0000);
	endtask

	task automatic t_power_mgmt();
		logic s;
		wr(idx_pmc, 8'h05);
		rdchk(idx_pmc, 32'h0000_0005);
		chk(xram_en, 32'h0000_0001);
		seen(6, s, 1'b0);
		chk(s, 32'h0000_0000);
		@(posedge hclk);
		ext_req <= 1'b1;
		seen(6, s, 1'b0);
		chk(s, 32'h0000_0001);
		@(posedge hclk);
		ext_req <= 1'b0;
		wr(idx_pmc, 8'h00);
		seen(6, s, 1'b0);
		chk(s, 32'h0000_0001);
		chk(xram_en, 32'h0000_0000);
	endtask

	task automatic t_idle();
		logic [7:0] n;
		wr(idx_pcr, 8'h01);
		repeat (2) @(posedge hclk);
		#1;
		chk(cpu_clk_en, 32'h0000_0000);
		chk(port_hold, 32'h0000_0001);
		n = instr_count;
		repeat (5) @(posedge hclk);
		#1;
		chk(instr_count, n);
		chk({ale_pin, program_fetch_strobe_pin}, 32'h0000_0003);
		@(posedge hclk);
		wake_req <= 1'b1;
		repeat (3) @(posedge hclk);
		#1;
		chk(cpu_clk_en, 32'h0000_0001);
		@(posedge hclk);
		wake_req <= 1'b0;
		rdchk(idx_pcr, 32'h0000_0000);
	endtask

	task automatic t_ext_reset();
		logic s;
		wr(idx_pmc, 8'h05);
		wr(idx_pcr, 8'h01);
		// seven high samples are one short of a valid reset
		@(posedge hclk);
		ext_rst_pin <= 1'b1;
		repeat (7) @(posedge hclk);
		ext_rst_pin <= 1'b0;
		seen(4, s, 1'b1);
		chk(s, 32'h0000_0000);
		@(posedge hclk);
		ext_rst_pin <= 1'b1;
		repeat (8) @(posedge hclk);
		// core reset stands only while the pin stays high, so look before release
		seen(2, s, 1'b1);
		@(posedge hclk);
		ext_rst_pin <= 1'b0;
		chk(s, 32'h0000_0001);
		repeat (5) @(posedge hclk);
		#1;
		chk({core_reset, port_hold, cpu_clk_en}, 32'h0000_0001);
		chk(instr_count != 8'h00, 32'h0000_0001);
		rdchk(idx_pmc, 32'h0000_0000);
		rdchk(idx_wdc, 32'h0000_0040);
	endtask

	task automatic t_timed_access();
		// bit 6 written as one so the power-on flag stays set
		wr(idx_wdc, 8'h42);
		rdchk(idx_wdc, 32'h0000_0040);
		wr(idx_key, 8'hAA);
		wr(idx_pmc, 8'h00);
		wr(idx_key, 8'h55);
		wr(idx_wdc, 8'h42);
		rdchk(idx_wdc, 32'h0000_0040);
		wr(idx_key, 8'hAA);
		wr(idx_key, 8'h55);
		wr(idx_wdc, 8'h42);
		rdchk(idx_wdc, 32'h0000_0042);
		repeat (16) @(posedge hclk);
		wr(idx_wdc, 8'h40);
		rdchk(idx_wdc, 32'h0000_0042);
		rdchk(idx_key, 32'h0000_0000);
	endtask

	task automatic t_watchdog();
		int n;
		wr(idx_cfg, 8'h04);
		wr(idx_key, 8'hAA);
		wr(idx_key, 8'h55);
		wr(idx_wdc, 8'h43);
		wr(idx_pcr, 8'h01);
		n = 0;
		while (wdt_irq !== 1'b1 && n < 200) begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk(wdt_irq, 32'h0000_0001);
		repeat (2) @(posedge hclk);
		#1;
		chk(cpu_clk_en, 32'h0000_0001);
		n = 0;
		while (core_reset !== 1'b1 && n < 700) begin
			@(posedge hclk);
			#1;
			n++;
		end
		n = 0;
		while (core_reset === 1'b1 && n < 20) begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk(n, 32'h0000_0008);
		rdchk(idx_wdc, 32'h0000_0046);
		chk(wdt_irq, 32'h0000_0000);
	endtask

	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset_values();
		t_power_mgmt();
		t_idle();
		t_ext_reset();
		t_timed_access();
		t_watchdog();
		end_of_test();
	end
endmodule
